// ---- scrc_cfg.svh ----
`ifndef SCRC_CFG_SVH
`define SCRC_CFG_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define SCRC_CMD_ROM_READ 8'h33
`define SCRC_CMD_PROT_READ 8'h69
`define SCRC_CMD_SCR_WRITE 8'h0f
`define SCRC_CMD_SCR_READ 8'haa
// ----------------------------------------
// crc and layout
// ----------------------------------------
`define SCRC_CRC16_POLY_REFL 16'ha001
`define SCRC_CRC8_POLY_REFL 8'h8c
`define SCRC_PAGE_BYTES 32
`define SCRC_SCR_LAST 5'h1f
`define SCRC_PWD_BYTES 8
`define SCRC_ROM_BYTES 8
`define SCRC_MEM_BYTES 256
`define SCRC_IDLE_BYTE 8'hff
// ----------------------------------------
// timing
// ----------------------------------------
`define SCRC_CLK_PERIOD_NS 4
`define SCRC_SLOT_PERIOD_NS 60
`define SCRC_SLOT_CYCLES ((`SCRC_SLOT_PERIOD_NS + `SCRC_CLK_PERIOD_NS - 1) / `SCRC_CLK_PERIOD_NS)
`define SCRC_MAX_RETRY 2
`endif

// ---- scrc_pkg.sv ----
`include "scrc_cfg.svh"
package scrc_pkg;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [11:0] {
    D_CMD = 12'h001, D_ROM = 12'h002, D_ALO = 12'h004, D_AHI = 12'h008,
    D_PWD = 12'h010, D_RDATA = 12'h020, D_WDATA = 12'h040, D_ES = 12'h080,
    D_SDATA = 12'h100, D_CRCLO = 12'h200, D_CRCHI = 12'h400, D_DONE = 12'h800
  } scrc_dstate_t;
  typedef enum logic [11:0] {
    H_IDLE = 12'h001, H_RST = 12'h002, H_CMD = 12'h004, H_ROM = 12'h008,
    H_ALO = 12'h010, H_AHI = 12'h020, H_PWD = 12'h040, H_WDATA = 12'h080,
    H_ES = 12'h100, H_RDATA = 12'h200, H_CRCLO = 12'h400, H_CRCHI = 12'h800
  } scrc_hstate_t;
  typedef enum logic [1:0] {
    OP_ROM = 2'h0, OP_PROT_READ = 2'h1, OP_SCR_WRITE = 2'h2, OP_SCR_READ = 2'h3
  } scrc_op_t;
  // ----------------------------------------
  // crc steps, lsb first as on the wire
  // ----------------------------------------
  function automatic logic [15:0] crc16Byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ `SCRC_CRC16_POLY_REFL;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : crc16Byte
  function automatic logic [7:0] crc8Byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ `SCRC_CRC8_POLY_REFL;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : crc8Byte
endpackage : scrc_pkg

// ---- scrc_link_if.sv ----
`timescale 1ns/1ps
interface scrc_link_if;
  logic wrValid;
  logic [7:0] wrByte;
  logic rdReq;
  logic rdValid;
  logic [7:0] rdByte;
  logic busReset;
  modport dev (input wrValid, input wrByte, input rdReq, input busReset, output rdValid, output rdByte);
  modport host (output wrValid, output wrByte, output rdReq, output busReset, input rdValid, input rdByte);
endinterface : scrc_link_if

// ---- scrc_device.sv ----
`timescale 1ns/1ps
`include "scrc_cfg.svh"
// ----------------------------------------
// device end of the serial link crc logic
// ----------------------------------------
module scrc_device #(
  parameter int MEM_BYTES = `SCRC_MEM_BYTES
) (
  input wire logic clock,
  input wire logic srst,
  scrc_link_if.dev link,
  input wire logic [55:0] romBody,
  input wire logic memWrEn,
  input wire logic [15:0] memWrAddr,
  input wire logic [7:0] memWrData,
  output logic [7:0] romCrc,
  output logic [4:0] endOffset,
  output logic [15:0] crcValue
);
  localparam int AW = $clog2(MEM_BYTES);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (MEM_BYTES < `SCRC_PAGE_BYTES || MEM_BYTES % `SCRC_PAGE_BYTES != 0 || MEM_BYTES > 65536) begin : gBadMem
    $error("MEM_BYTES must be a multiple of 32 between 32 and 65536");
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] scratch [`SCRC_PAGE_BYTES];
  scrc_pkg::scrc_dstate_t state;
  scrc_pkg::scrc_dstate_t next_state;
  logic [7:0] cmd;
  logic [15:0] addr;
  logic [2:0] idx;
  logic [15:0] crc;
  logic [15:0] next_crc;
  logic shiftEn;
  logic [7:0] shiftByte;
  logic [7:0] txByte;
  logic addrStep;
  logic idxStep;
  logic atPageEnd;
  logic [7:0] romCrcCalc;

  assign atPageEnd = (addr[4:0] == `SCRC_SCR_LAST);

  // ----------------------------------------
  // identifier crc
  // ----------------------------------------
  always_comb begin
    romCrcCalc = 8'h00;
    for (int b = 0; b < 7; b++) begin
      romCrcCalc = scrc_pkg::crc8Byte(romCrcCalc, romBody[b*8 +: 8]);
    end
  end

  // recomputed every cycle so a strap change is followed without a reset
  always_ff @(posedge clock) begin
    if (srst) begin
      romCrc <= 8'h00;
    end else begin
      romCrc <= romCrcCalc;
    end
  end

  // ----------------------------------------
  // sequencing and crc feed
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_crc = crc;
    shiftEn = 1'b0;
    shiftByte = link.wrByte;
    txByte = `SCRC_IDLE_BYTE;
    addrStep = 1'b0;
    idxStep = 1'b0;
    case (state)
      scrc_pkg::D_CMD: begin
        if (link.wrValid) begin
          next_crc = 16'h0000;
          shiftEn = 1'b1;
          case (link.wrByte)
            `SCRC_CMD_ROM_READ: next_state = scrc_pkg::D_ROM;
            `SCRC_CMD_PROT_READ, `SCRC_CMD_SCR_WRITE, `SCRC_CMD_SCR_READ: next_state = scrc_pkg::D_ALO;
            default: next_state = scrc_pkg::D_DONE;
          endcase
        end
      end
      scrc_pkg::D_ROM: begin
        txByte = (idx == 3'h7) ? romCrc : romBody[{idx, 3'b000} +: 8];
        if (link.rdReq) begin
          idxStep = 1'b1;
          if (idx == 3'h7) begin
            next_state = scrc_pkg::D_DONE;
          end
        end
      end
      scrc_pkg::D_ALO: begin
        if (link.wrValid) begin
          shiftEn = 1'b1;
          next_state = scrc_pkg::D_AHI;
        end
      end
      scrc_pkg::D_AHI: begin
        if (link.wrValid) begin
          shiftEn = 1'b1;
          case (cmd)
            `SCRC_CMD_PROT_READ: next_state = scrc_pkg::D_PWD;
            `SCRC_CMD_SCR_WRITE: next_state = scrc_pkg::D_WDATA;
            default: next_state = scrc_pkg::D_ES;
          endcase
        end
      end
      scrc_pkg::D_PWD: begin
        // password is counted off but kept out of the crc
        if (link.wrValid) begin
          idxStep = 1'b1;
          if (idx == 3'h7) begin
            next_state = scrc_pkg::D_RDATA;
          end
        end
      end
      scrc_pkg::D_RDATA: begin
        txByte = mem[addr[AW-1:0]];
        if (link.rdReq) begin
          shiftByte = txByte;
          shiftEn = 1'b1;
          addrStep = 1'b1;
          if (atPageEnd) begin
            next_state = scrc_pkg::D_CRCLO;
          end
        end
      end
      scrc_pkg::D_WDATA: begin
        if (link.wrValid) begin
          shiftEn = 1'b1;
          addrStep = 1'b1;
          if (atPageEnd) begin
            next_state = scrc_pkg::D_CRCLO;
          end
        end
      end
      scrc_pkg::D_ES: begin
        txByte = {3'b000, endOffset};
        if (link.rdReq) begin
          shiftByte = txByte;
          shiftEn = 1'b1;
          next_state = scrc_pkg::D_SDATA;
        end
      end
      scrc_pkg::D_SDATA: begin
        txByte = scratch[addr[4:0]];
        if (link.rdReq) begin
          shiftByte = txByte;
          shiftEn = 1'b1;
          addrStep = 1'b1;
          if (atPageEnd) begin
            next_state = scrc_pkg::D_CRCLO;
          end
        end
      end
      scrc_pkg::D_CRCLO: begin
        txByte = ~crc[7:0];
        if (link.rdReq) begin
          next_state = scrc_pkg::D_CRCHI;
        end
      end
      scrc_pkg::D_CRCHI: begin
        txByte = ~crc[15:8];
        if (link.rdReq) begin
          if (cmd == `SCRC_CMD_PROT_READ && addr[AW-1:0] != '0) begin
            next_crc = 16'h0000;
            next_state = scrc_pkg::D_RDATA;
          end else begin
            next_state = scrc_pkg::D_DONE;
          end
        end
      end
      scrc_pkg::D_DONE: begin
        txByte = `SCRC_IDLE_BYTE;
      end
      default: begin
        next_state = scrc_pkg::D_DONE;
      end
    endcase
    if (shiftEn) begin
      next_crc = scrc_pkg::crc16Byte(next_crc, shiftByte);
    end
    if (link.busReset) begin
      next_state = scrc_pkg::D_CMD;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= scrc_pkg::D_CMD;
      crc <= 16'h0000;
    end else begin
      state <= next_state;
      crc <= next_crc;
    end
  end

  // ----------------------------------------
  // command, address and counters
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst || link.busReset) begin
      cmd <= 8'h00;
      addr <= 16'h0000;
      idx <= 3'h0;
    end else begin
      if (state == scrc_pkg::D_CMD && link.wrValid) begin
        cmd <= link.wrByte;
      end
      if (state == scrc_pkg::D_ALO && link.wrValid) begin
        addr[7:0] <= link.wrByte;
      end
      if (state == scrc_pkg::D_AHI && link.wrValid) begin
        addr[15:8] <= link.wrByte;
      end
      if (addrStep) begin
        addr <= addr + 16'h0001;
      end
      if (idxStep) begin
        idx <= idx + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // scratchpad and memory writes
  // ----------------------------------------
  // any start offset is taken; the page end stops the write
  always_ff @(posedge clock) begin
    if (srst) begin
      endOffset <= 5'h00;
    end else if (state == scrc_pkg::D_WDATA && link.wrValid && !link.busReset) begin
      endOffset <= addr[4:0];
    end
  end

  always_ff @(posedge clock) begin
    if (state == scrc_pkg::D_WDATA && link.wrValid && !link.busReset) begin
      scratch[addr[4:0]] <= link.wrByte;
    end
  end

  always_ff @(posedge clock) begin
    if (memWrEn) begin
      mem[memWrAddr[AW-1:0]] <= memWrData;
    end
  end

  // ----------------------------------------
  // link answer
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      link.rdValid <= 1'b0;
      link.rdByte <= `SCRC_IDLE_BYTE;
      crcValue <= 16'h0000;
    end else begin
      link.rdValid <= link.rdReq && !link.busReset;
      link.rdByte <= link.rdReq ? txByte : link.rdByte; // answer byte held between requests
      crcValue <= crc;
    end
  end
endmodule : scrc_device

// ---- scrc_host.sv ----
`timescale 1ns/1ps
`include "scrc_cfg.svh"
// ----------------------------------------
// master end: runs one transfer per start
// ----------------------------------------
module scrc_host #(
  parameter int SLOT_CYCLES = `SCRC_SLOT_CYCLES,
  parameter int MAX_RETRY = `SCRC_MAX_RETRY
) (
  input wire logic clock,
  input wire logic srst,
  scrc_link_if.host link,
  input wire logic start,
  input wire scrc_pkg::scrc_op_t op,
  input wire logic [15:0] addr,
  input wire logic [5:0] len,
  input wire logic [63:0] password,
  input wire logic [7:0] wrData,
  output logic wrTake,
  output logic [7:0] rdData,
  output logic rdStrobe,
  output logic busy,
  output logic crcOk,
  output logic crcErr
);
  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (SLOT_CYCLES < 2 || SLOT_CYCLES > 255 || MAX_RETRY < 0 || MAX_RETRY > 15) begin : gBadParam
    $error("SLOT_CYCLES must be 2..255 and MAX_RETRY 0..15");
  end

  scrc_pkg::scrc_hstate_t state;
  scrc_pkg::scrc_op_t opReg;
  logic [15:0] addrReg;
  logic [5:0] lenReg;
  logic [63:0] pwdReg;
  logic [5:0] cnt;
  logic [7:0] gap;
  logic pend;
  logic [15:0] crc;
  logic [7:0] crc8;
  logic [7:0] crcLo;
  logic [3:0] tries;
  logic ready;
  logic rx;
  logic [5:0] toEnd;

  assign ready = (gap == 8'h00) && !pend;
  assign rx = pend && link.rdValid;
  assign toEnd = 6'h20 - {1'b0, addrReg[4:0]};

  // ----------------------------------------
  // transfer sequence
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= scrc_pkg::H_IDLE;
      opReg <= scrc_pkg::OP_ROM;
      addrReg <= 16'h0000;
      lenReg <= 6'h00;
      pwdReg <= 64'h0;
      cnt <= 6'h00;
      gap <= 8'h00;
      pend <= 1'b0;
      crc <= 16'h0000;
      crc8 <= 8'h00;
      crcLo <= 8'h00;
      tries <= 4'h0;
      link.wrValid <= 1'b0;
      link.wrByte <= 8'h00;
      link.rdReq <= 1'b0;
      link.busReset <= 1'b0;
      wrTake <= 1'b0;
      rdData <= 8'h00;
      rdStrobe <= 1'b0;
      busy <= 1'b0;
      crcOk <= 1'b0;
      crcErr <= 1'b0;
    end else begin
      link.wrValid <= 1'b0;
      link.rdReq <= 1'b0;
      link.busReset <= 1'b0;
      wrTake <= 1'b0;
      rdStrobe <= 1'b0;
      crcOk <= 1'b0;
      crcErr <= 1'b0;
      if (gap != 8'h00) begin
        gap <= gap - 8'h01;
      end
      if (rx) begin
        pend <= 1'b0;
      end
      case (state)
        scrc_pkg::H_IDLE: begin
          busy <= 1'b0;
          if (start) begin
            opReg <= op;
            addrReg <= addr;
            lenReg <= len;
            pwdReg <= password;
            tries <= 4'h0;
            busy <= 1'b1;
            state <= scrc_pkg::H_RST;
          end
        end
        scrc_pkg::H_RST: begin
          link.busReset <= 1'b1;
          gap <= 8'(SLOT_CYCLES);
          state <= scrc_pkg::H_CMD;
        end
        scrc_pkg::H_CMD: begin
          if (ready) begin
            link.wrValid <= 1'b1;
            gap <= 8'(SLOT_CYCLES);
            cnt <= 6'h00;
            crc8 <= 8'h00;
            case (opReg)
              scrc_pkg::OP_ROM: link.wrByte <= `SCRC_CMD_ROM_READ;
              scrc_pkg::OP_PROT_READ: link.wrByte <= `SCRC_CMD_PROT_READ;
              scrc_pkg::OP_SCR_WRITE: link.wrByte <= `SCRC_CMD_SCR_WRITE;
              default: link.wrByte <= `SCRC_CMD_SCR_READ;
            endcase
            case (opReg)
              scrc_pkg::OP_ROM: crc <= 16'h0000;
              scrc_pkg::OP_PROT_READ: crc <= scrc_pkg::crc16Byte(16'h0000, `SCRC_CMD_PROT_READ);
              scrc_pkg::OP_SCR_WRITE: crc <= scrc_pkg::crc16Byte(16'h0000, `SCRC_CMD_SCR_WRITE);
              default: crc <= scrc_pkg::crc16Byte(16'h0000, `SCRC_CMD_SCR_READ);
            endcase
            state <= (opReg == scrc_pkg::OP_ROM) ? scrc_pkg::H_ROM : scrc_pkg::H_ALO;
          end
        end
        scrc_pkg::H_ROM: begin
          if (ready) begin
            link.rdReq <= 1'b1;
            pend <= 1'b1;
            gap <= 8'(SLOT_CYCLES);
          end else if (rx) begin
            rdData <= link.rdByte;
            rdStrobe <= 1'b1;
            cnt <= cnt + 6'h01;
            if (cnt < 6'h07) begin
              crc8 <= scrc_pkg::crc8Byte(crc8, link.rdByte);
            end else begin
              crcOk <= (link.rdByte == crc8);
              crcErr <= (link.rdByte != crc8);
              state <= (link.rdByte != crc8 && tries < 4'(MAX_RETRY)) ? scrc_pkg::H_RST : scrc_pkg::H_IDLE;
              tries <= tries + 4'h1;
            end
          end
        end
        scrc_pkg::H_ALO, scrc_pkg::H_AHI: begin
          if (ready) begin
            link.wrValid <= 1'b1;
            gap <= 8'(SLOT_CYCLES);
            link.wrByte <= (state == scrc_pkg::H_ALO) ? addrReg[7:0] : addrReg[15:8];
            crc <= scrc_pkg::crc16Byte(crc, (state == scrc_pkg::H_ALO) ? addrReg[7:0] : addrReg[15:8]);
            if (state == scrc_pkg::H_ALO) begin
              state <= scrc_pkg::H_AHI;
            end else begin
              case (opReg)
                scrc_pkg::OP_PROT_READ: state <= scrc_pkg::H_PWD;
                scrc_pkg::OP_SCR_WRITE: state <= (lenReg == 6'h00) ? scrc_pkg::H_IDLE : scrc_pkg::H_WDATA;
                default: state <= scrc_pkg::H_ES;
              endcase
              cnt <= (lenReg < toEnd) ? lenReg : toEnd;
              if (opReg == scrc_pkg::OP_PROT_READ) begin
                cnt <= 6'h00;
              end
            end
          end
        end
        scrc_pkg::H_PWD: begin
          if (ready) begin
            link.wrValid <= 1'b1;
            gap <= 8'(SLOT_CYCLES);
            link.wrByte <= pwdReg[{cnt[2:0], 3'b000} +: 8];
            cnt <= cnt + 6'h01;
            if (cnt == 6'h07) begin
              cnt <= toEnd;
              state <= scrc_pkg::H_RDATA;
            end
          end
        end
        scrc_pkg::H_WDATA: begin
          if (ready) begin
            link.wrValid <= 1'b1;
            link.wrByte <= wrData;
            wrTake <= 1'b1;
            gap <= 8'(SLOT_CYCLES);
            crc <= scrc_pkg::crc16Byte(crc, wrData);
            cnt <= cnt - 6'h01;
            if (cnt == 6'h01) begin
              state <= (lenReg >= toEnd) ? scrc_pkg::H_CRCLO : scrc_pkg::H_IDLE;
            end
          end
        end
        scrc_pkg::H_ES, scrc_pkg::H_RDATA, scrc_pkg::H_CRCLO, scrc_pkg::H_CRCHI: begin
          if (ready) begin
            link.rdReq <= 1'b1;
            pend <= 1'b1;
            gap <= 8'(SLOT_CYCLES);
          end else if (rx) begin
            case (state)
              scrc_pkg::H_ES: begin
                crc <= scrc_pkg::crc16Byte(crc, link.rdByte);
                cnt <= toEnd;
                state <= scrc_pkg::H_RDATA;
              end
              scrc_pkg::H_RDATA: begin
                rdData <= link.rdByte;
                rdStrobe <= 1'b1;
                crc <= scrc_pkg::crc16Byte(crc, link.rdByte);
                cnt <= cnt - 6'h01;
                if (cnt == 6'h01) begin
                  state <= scrc_pkg::H_CRCLO;
                end
              end
              scrc_pkg::H_CRCLO: begin
                crcLo <= link.rdByte;
                state <= scrc_pkg::H_CRCHI;
              end
              default: begin
                crcOk <= ({link.rdByte, crcLo} == ~crc);
                crcErr <= ({link.rdByte, crcLo} != ~crc);
                tries <= tries + 4'h1;
                // writes are not repeated; the user decides on those
                if ({link.rdByte, crcLo} != ~crc && opReg != scrc_pkg::OP_SCR_WRITE && tries < 4'(MAX_RETRY)) begin
                  state <= scrc_pkg::H_RST;
                end else begin
                  state <= scrc_pkg::H_IDLE;
                end
              end
            endcase
          end
        end
        default: begin
          state <= scrc_pkg::H_IDLE;
        end
      endcase
    end
  end
endmodule : scrc_host

// ---- scrc_chk.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// link checker
// ----------------------------------------
module scrc_chk #(
  parameter int SLOT_CYCLES = 2
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic wrValid,
  input wire logic [7:0] wrByte,
  input wire logic rdReq,
  input wire logic rdValid,
  input wire logic [7:0] rdByte,
  input wire logic busReset
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  logic [7:0] gap;
  wire act = wrValid | rdReq | busReset;
  // saturates so a long idle never wraps into a false gap
  always_ff @(posedge clock) begin
    if (srst) begin
      gap <= 8'hff;
    end else if (act) begin
      gap <= 8'h00;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end
  property p_answer; rdReq && !busReset |=> rdValid; endproperty
  a_answer: assert property (p_answer) else $error("read not answered next cycle");
  property p_cause; rdValid |-> $past(rdReq) && !$past(busReset); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_hold; !rdReq |=> $stable(rdByte); endproperty
  a_hold: assert property (p_hold) else $error("read byte moved without request");
  property p_abort; rdReq && busReset |=> !rdValid; endproperty
  a_abort: assert property (p_abort) else $error("answer despite abort");
  property p_spacing; act |-> gap >= SLOT_CYCLES; endproperty
  a_spacing: assert property (p_spacing) else $error("slot too short");
  property p_single; rdReq |-> !wrValid && !rdValid; endproperty
  a_single: assert property (p_single) else $error("overlapping link actions");
  property p_pulse; rdValid |=> !rdValid [*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than a pulse");
  property p_wrQuiet; wrValid |-> !busReset && !rdValid; endproperty
  a_wrQuiet: assert property (p_wrQuiet) else $error("write collides");
endmodule : scrc_chk

// ---- serial_bus_crc_generation_tb.sv ----
`timescale 1ns/1ps
module serial_bus_crc_generation_tb;
  // ----------------------------------------
  // stimulus and instances
  // ----------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  scrc_pkg::scrc_op_t op = scrc_pkg::OP_ROM;
  logic [15:0] addr = 16'h0000;
  logic [5:0] len = 6'h00;
  logic [63:0] password = 64'h0;
  logic [7:0] wrData = 8'h00;
  logic [55:0] romBody = 56'h0;
  logic memWrEn = 1'b0;
  logic [15:0] memWrAddr = 16'h0000;
  logic [7:0] memWrData = 8'h00;
  logic wrTake, rdStrobe, busy, crcOk, crcErr;
  logic [7:0] rdData, romCrc;
  logic [4:0] endOffset;
  logic [15:0] crcValue, a, c;
  logic [31:0] seed = 32'h00010498;
  int miscompares = 0, numChecks = 0, nOk = 0, nErr = 0, cyc = 0, m = 0, eo = 0;
  logic [7:0] lnk[$], dat[$], wq[$], ex[$], e2[$], mem[64], scr[32];
  always #2 clock = ~clock;
  scrc_link_if link();
  scrc_device #(.MEM_BYTES(64)) scrc_device_inst (.clock(clock), .srst(srst), .link(link), .romBody(romBody),
    .memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData), .romCrc(romCrc), .endOffset(endOffset),
    .crcValue(crcValue));
  scrc_host #(.SLOT_CYCLES(2)) scrc_host_inst (.clock(clock), .srst(srst), .link(link), .start(start), .op(op),
    .addr(addr), .len(len), .password(password), .wrData(wrData), .wrTake(wrTake), .rdData(rdData),
    .rdStrobe(rdStrobe), .busy(busy), .crcOk(crcOk), .crcErr(crcErr));
  scrc_chk #(.SLOT_CYCLES(2)) scrc_chk_inst (.clock(clock), .srst(srst), .wrValid(link.wrValid),
    .wrByte(link.wrByte), .rdReq(link.rdReq), .rdValid(link.rdValid), .rdByte(link.rdByte),
    .busReset(link.busReset));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] crc(input logic [7:0] q[$], input logic [15:0] poly);
    logic [15:0] r;
    r = 16'h0000;
    foreach (q[i]) begin
      for (int b = 0; b < 8; b++) begin
        r = (r[0] ^ q[i][b]) ? ((r >> 1) ^ poly) : (r >> 1);
      end
    end
    return r;
  endfunction : crc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic cmpq(input logic [7:0] g[$], input logic [7:0] e[$], input string msg);
    chk(16'(g.size()), 16'(e.size()), msg);
    foreach (e[i]) chk({8'h00, g[i]}, {8'h00, e[i]}, msg);
  endtask : cmpq
  // with hdr set, the link bytes after the header, then the inverted crc over all of ex
  task automatic fin(input int hdr, input string msg);
    c = ~crc(ex, 16'ha001);
    e2 = {};
    if (hdr) e2 = ex[3:$];
    e2.push_back(c[7:0]);
    e2.push_back(c[15:8]);
    cmpq(lnk, e2, msg);
    chk(16'(nOk), 16'h0001, msg);
    chk(16'(nErr), 16'h0000, msg);
  endtask : fin
  task automatic run(input scrc_pkg::scrc_op_t o, input logic [15:0] ad, input logic [5:0] n);
    int t;
    lnk = {};
    dat = {};
    wq = {};
    nOk = 0;
    nErr = 0;
    op = o;
    addr = ad;
    len = n;
    password = {rnd(), rnd()};
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    t = 0;
    @(negedge clock);
    while (busy !== 1'b0 && t < 20000) begin
      @(negedge clock);
      t++;
    end
    if (t >= 20000) miscompares++;
    // late pulses may trail the fall of busy
    repeat (3) @(negedge clock);
  endtask : run
  task automatic stopTest();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stopTest
  // ----------------------------------------
  // monitor and timeout
  // ----------------------------------------
  always @(negedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      stopTest();
    end
    if (link.rdValid === 1'b1) lnk.push_back(link.rdByte);
    if (rdStrobe === 1'b1) dat.push_back(rdData);
    if (crcOk === 1'b1) nOk++;
    if (crcErr === 1'b1) nErr++;
    // new byte only after the host took the last one
    if (wrTake === 1'b1) begin
      wq.push_back(wrData);
      wrData = 8'(rnd());
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clock);
    srst = 1'b0;
    for (int i = 0; i < 64; i++) begin
      memWrEn = 1'b1;
      memWrAddr = 16'(i);
      memWrData = 8'(rnd());
      mem[i] = memWrData;
      @(negedge clock);
    end
    memWrEn = 1'b0;
    repeat (2) begin
      romBody = {24'(rnd()), rnd()};
      ex = {};
      for (int i = 0; i < 7; i++) ex.push_back(romBody[8*i +: 8]);
      run(scrc_pkg::OP_ROM, 16'h0000, 6'h00);
      ex.push_back(8'(crc(ex, 16'h008c)));
      chk({8'h00, romCrc}, {8'h00, ex[7]}, "rom crc");
      cmpq(lnk, ex, "rom link");
      cmpq(dat, ex, "rom data");
      chk(16'(nOk), 16'h0001, "rom crc ok");
      $display("test rom done");
    end
    for (int k = 0; k < 6; k++) begin
      a = 16'(rnd());
      if (k == 0) a[4:0] = 5'h00;
      len = (k == 0) ? 6'h20 : 6'(1 + rnd() % 32);
      m = (32 - a[4:0] < len) ? 32 - a[4:0] : len;
      run(scrc_pkg::OP_SCR_WRITE, a, len);
      ex = {8'h0f, a[7:0], a[15:8]};
      foreach (wq[i]) scr[a[4:0] + i] = wq[i];
      ex = {ex, wq};
      eo = a[4:0] + m - 1;
      chk(16'(wq.size()), 16'(m), "write count");
      chk({11'h000, endOffset}, 16'(eo), "end offset");
      if (eo == 31) begin
        fin(0, "write crc");
        chk(crcValue, ~c, "write crc reg");
      end else begin
        chk(16'(nOk + nErr), 16'h0000, "no crc");
        chk(16'(lnk.size()), 16'h0000, "no crc");
        foreach (lnk[i]) chk({8'h00, lnk[i]}, 16'h00ff, "no crc");
      end
      $display("test write done");
    end
    for (int k = 0; k < 6; k++) begin
      a = 16'(rnd() % 64);
      if (k == 0) a[4:0] = 5'h1f;
      ex = {};
      for (int i = a[4:0]; i < 32; i++) ex.push_back(k[0] ? scr[i] : mem[{a[5], 5'(i)}]);
      run(k[0] ? scrc_pkg::OP_SCR_READ : scrc_pkg::OP_PROT_READ, a, 6'h00);
      cmpq(dat, ex, "read data");
      if (k[0]) ex.push_front({3'h0, 5'(eo)});
      ex = {(k[0] ? 8'haa : 8'h69), a[7:0], a[15:8], ex};
      fin(1, "read crc");
      chk(crcValue, (!k[0] && !a[5]) ? 16'h0000 : ~c, "crc reg");
      $display("test read done");
    end
    stopTest();
  end
endmodule : serial_bus_crc_generation_tb
